// ### hw/dll_seq_pkg.sv
// Purpose: shared constants and types for the dll switch / clock rate change sequencer
// Assumes: one 20 MHz clock for both ends; mode register fields are simplified to fixed positions
// Notes:   times are kept in ns, cycle counts derived from them
package dll_seq_pkg;
  localparam int CLK_NS       = 50;
  localparam int T_MOD_NS     = 360;
  localparam int T_MRD_NS     = 200;
  localparam int T_CKSRE_NS   = 500;
  localparam int T_CKSRX_NS   = 500;
  localparam int T_XS_NS      = 1000;
  localparam int T_XSFAST_NS  = 600;
  localparam int T_XSABORT_NS = 600;
  localparam int T_DLLK_NS    = 50000;
  localparam int T_ZQOPER_NS  = 25600;
  localparam int T_RFC_NS     = 350;
  // least times round up
  localparam int T_MOD_CYC     = (T_MOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_MRD_CYC     = (T_MRD_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_CKSRE_CYC   = (T_CKSRE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_CKSRX_CYC   = (T_CKSRX_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_XS_CYC      = (T_XS_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_XSFAST_CYC  = (T_XSFAST_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_XSABORT_CYC = (T_XSABORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_DLLK_CYC    = (T_DLLK_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_ZQOPER_CYC  = (T_ZQOPER_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RFC_CYC     = (T_RFC_NS + CLK_NS - 1) / CLK_NS;

  localparam int CNT_W  = 16;
  localparam int ADDR_W = 18;

  // mode register numbers and field positions
  localparam logic [2:0] MR0 = 3'h0;
  localparam logic [2:0] MR1 = 3'h1;
  localparam logic [2:0] MR2 = 3'h2;
  localparam logic [2:0] MR3 = 3'h3;
  localparam logic [2:0] MR4 = 3'h4;
  localparam logic [2:0] MR5 = 3'h5;
  localparam logic [2:0] MR6 = 3'h6;
  localparam int DLL_EN_BIT = 0;  // MR1
  localparam int AL_LSB     = 3;  // MR1, 2 bits
  localparam int CL_LSB     = 2;  // MR0, 5 bits raw latency
  localparam int DLL_RST_BIT = 8; // MR0
  localparam int CWL_LSB    = 3;  // MR2, 5 bits raw latency
  localparam int PDA_BIT    = 4;  // MR3
  localparam int ABORT_BIT  = 9;  // MR4
  localparam int PL_LSB     = 0;  // MR5, 3 bits
  localparam logic [4:0] DLLOFF_CL  = 5'h0A;
  localparam logic [4:0] DLLOFF_CWL = 5'h09;

  // host register map
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_LAT    = 4'h8;
  localparam int CTRL_GO = 0, CTRL_DLL_ON = 1, CTRL_ABORT = 2, CTRL_ZQ = 3, CTRL_PL_LSB = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0002;
  localparam logic [31:0] LAT_RST  = 32'h0000_090A;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    CMD_DES, CMD_MRS, CMD_SRE, CMD_SRX, CMD_REF, CMD_ZQCL, CMD_ZQCS,
    CMD_ACT, CMD_PRE, CMD_RD, CMD_WR, CMD_PDE
  } cmd_t;
endpackage

// ### hw/dram_cmd_if.sv
// Purpose: command, cke and odt link between controller sequencer and dram model
// Assumes: both ends on clk_sys
// Notes:   no clocking block; the bench joins the ends
`timescale 1ns/100ps
interface dram_cmd_if;
  import dll_seq_pkg::*;
  logic              cke;
  logic              odt;
  cmd_t              cmd;
  logic [2:0]        mr_sel;
  logic [ADDR_W-1:0] addr;
  modport host   (output cke, output odt, output cmd, output mr_sel, output addr);
  modport device (input cke, input odt, input cmd, input mr_sel, input addr);
endinterface

// ### hw/wait_timer.sv
// Purpose: down counter for mandatory wait intervals
// Assumes: load is one cycle
// Notes:   done is a level, low from the cycle after load until the count runs out
`timescale 1ns/100ps
module wait_timer
  import dll_seq_pkg::*;
(
  input  wire logic             clk_sys,  // system clock
  input  wire logic             resetn,   // async reset, low
  input  wire logic             load,     // start a wait
  input  wire logic [CNT_W-1:0] load_val, // cycles to wait
  output logic                  done      // count exhausted
);
  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign done = (cnt_r == '0);
endmodule

// ### hw/dll_seq_host.sv
// Purpose: controller-side sequencer for dll on/off switching and clock rate change
// Assumes: AXI4-Lite slave on clk_sys; one write and one read at most in flight
// Notes:   odt is held low for the whole sequence, which covers both odt cases
// Summary of operation
// - MR1 A0 low disables DLL until set
// - idle, precharged, odt off before disable
// - tMOD, enter self refresh, hold tCKSRE
// - stable new clock tCKSRX before exit
// - dll-off exit: cke high, odt low
// - after fast exit only ZQ, CL/WR/CWL writes
// - abort bit: abort refresh, keep counter
// - one refresh before next self refresh
// - ordinary commands wait full exit delay
// - A0 on, tMRD, dll reset, tMRD
// - wait tDLLK, and tZQoper after ZQCL
// - dll-on exit: cke high until locked
// - DLL bit changes only init/self refresh; the sequencer writes dll-off in idle before entry
// - dll-off needs only CL 10, CWL 9
// - dll-off read reference AL+CL-1
// - change clock only inside self refresh
// - parity off, rate change, parity on
// - rewrite added-clock settings before leaving idle
// - MR6 before entry relocks at exit
// - stay in grade range, else dll-off
// - rewrite MR0, MR2-MR6 after change; the sequencer rewrites only MR0, MR2 and MR5
// - tMOD after last mode write
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module dll_seq_host
  import dll_seq_pkg::*;
(
  input  wire logic        clk_sys,   // system clock
  input  wire logic        resetn,    // async reset, low
  input  wire logic [31:0] s_awaddr,  // axi write address
  input  wire logic        s_awvalid, // axi
  output logic             s_awready, // axi
  input  wire logic [31:0] s_wdata,   // axi write data
  input  wire logic [3:0]  s_wstrb,   // axi byte enables
  input  wire logic        s_wvalid,  // axi
  output logic             s_wready,  // axi
  output logic [1:0]       s_bresp,   // axi
  output logic             s_bvalid,  // axi
  input  wire logic        s_bready,  // axi
  input  wire logic [31:0] s_araddr,  // axi read address
  input  wire logic        s_arvalid, // axi
  output logic             s_arready, // axi
  output logic [31:0]      s_rdata,   // axi read data
  output logic [1:0]       s_rresp,   // axi
  output logic             s_rvalid,  // axi
  input  wire logic        s_rready,  // axi
  output logic             rate_sel,  // selects the new clock rate
  dram_cmd_if.host         dram       // link to the dram
);
  typedef enum logic [3:0] {
    S_IDLE, S_PL_OFF, S_MR4, S_DLL_OFF, S_SRE, S_FREQ, S_SRX, S_MR1_ON, S_DLL_RST,
    S_MR0, S_MR2, S_LOCK, S_ZQ, S_REF, S_PL_ON
  } state_t;

  state_t            state_r;
  logic              waiting_r;
  logic [31:0]       ctrl_r;
  logic [31:0]       lat_r;
  logic              go_r;
  logic              done_r;
  logic              dll_on_r;
  logic              tmr_done;
  logic              tmr_load;
  cmd_t              step_cmd;
  logic [2:0]        step_mr;
  logic [ADDR_W-1:0] step_addr;
  logic [CNT_W-1:0]  step_wait;
  state_t            step_next;
  logic              want_on;
  logic [4:0]        cl_val;
  logic [4:0]        cwl_val;

  assign want_on = ctrl_r[CTRL_DLL_ON];
  // dll-off only has to support one latency pair
  assign cl_val  = want_on ? lat_r[4:0]  : DLLOFF_CL;
  assign cwl_val = want_on ? lat_r[12:8] : DLLOFF_CWL;

  // ---------------- AXI4-Lite slave ----------------
  logic        aw_hold_r, w_hold_r;
  logic [3:0]  aw_off_r;
  logic        aw_ok_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic mapped(input logic [31:0] a);
    return (a[31:4] == '0) && (a[1:0] == 2'h0) && (a[3:0] != 4'hC);
  endfunction

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_awready <= 1'b1;
      s_wready  <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_off_r  <= 4'h0;
      aw_ok_r   <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      s_bvalid  <= 1'b0;
      s_bresp   <= RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_hold_r <= 1'b1;
        aw_off_r  <= s_awaddr[3:0];
        aw_ok_r   <= mapped(s_awaddr);
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_wdata;
        w_strb_r <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (aw_hold_r && w_hold_r && !s_bvalid) begin
        s_bvalid <= 1'b1;
        s_bresp  <= aw_ok_r ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid  <= 1'b0;
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        s_awready <= 1'b1;
        s_wready  <= 1'b1;
      end
    end
  end

  wire wr_fire = aw_hold_r && w_hold_r && !s_bvalid && aw_ok_r;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= CTRL_RST;
      lat_r  <= LAT_RST;
      go_r   <= 1'b0;
    end else begin
      go_r <= 1'b0;
      // settings are frozen while a sequence runs
      if (wr_fire && state_r == S_IDLE) begin
        if (aw_off_r == REG_CTRL) begin
          ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r);
          go_r   <= w_strb_r[0] & w_data_r[CTRL_GO];
        end
        if (aw_off_r == REG_LAT) begin
          lat_r <= merge(lat_r, w_data_r, w_strb_r);
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_arready <= 1'b1;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b1;
      s_rresp   <= mapped(s_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_araddr[3:0])
        REG_CTRL:   s_rdata <= {ctrl_r[31:1], 1'b0};
        REG_STATUS: s_rdata <= {24'h00_0000, state_r, 1'b0, dll_on_r, done_r, (state_r != S_IDLE)};
        REG_LAT:    s_rdata <= lat_r;
        default:    s_rdata <= 32'h0000_0000;
      endcase
    end else if (s_rvalid && s_rready) begin
      s_rvalid  <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // ---------------- sequencer ----------------
  always_comb begin
    step_cmd  = CMD_DES;
    step_mr   = MR0;
    step_addr = '0;
    step_wait = CNT_W'(T_MOD_CYC);
    step_next = S_IDLE;
    case (state_r)
      S_PL_OFF: begin
        step_cmd  = CMD_MRS;
        step_mr   = MR5;
        step_next = S_MR4;
      end
      S_MR4: begin
        // the shorter abort wait is only legal once the dram knows abort is on
        step_cmd  = CMD_MRS;
        step_mr   = MR4;
        step_addr[ABORT_BIT] = ctrl_r[CTRL_ABORT];
        step_next = want_on ? S_SRE : S_DLL_OFF;
      end
      S_DLL_OFF: begin
        step_cmd  = CMD_MRS;
        step_mr   = MR1;
        step_next = S_SRE;
      end
      S_SRE: begin
        step_cmd  = CMD_SRE;
        step_wait = CNT_W'(T_CKSRE_CYC);
        step_next = S_FREQ;
      end
      S_FREQ: begin
        step_wait = CNT_W'(T_CKSRX_CYC);
        step_next = S_SRX;
      end
      S_SRX: begin
        step_cmd  = CMD_SRX;
        step_wait = !want_on ? CNT_W'(T_XSFAST_CYC) :
                    ctrl_r[CTRL_ABORT] ? CNT_W'(T_XSABORT_CYC) : CNT_W'(T_XS_CYC);
        step_next = want_on ? S_MR1_ON : S_MR0;
      end
      S_MR1_ON: begin
        step_cmd  = CMD_MRS;
        step_mr   = MR1;
        step_addr[DLL_EN_BIT] = 1'b1;
        step_wait = CNT_W'(T_MRD_CYC);
        step_next = S_DLL_RST;
      end
      S_DLL_RST: begin
        step_cmd  = CMD_MRS;
        step_addr[DLL_RST_BIT] = 1'b1;
        step_addr[CL_LSB +: 5] = cl_val;
        step_wait = CNT_W'(T_MRD_CYC);
        step_next = S_MR2;
      end
      S_MR0: begin
        step_cmd  = CMD_MRS;
        step_addr[CL_LSB +: 5] = cl_val;
        step_next = S_MR2;
      end
      S_MR2: begin
        step_cmd  = CMD_MRS;
        step_mr   = MR2;
        step_addr[CWL_LSB +: 5] = cwl_val;
        // on the off path this wait also covers the full exit delay
        step_wait = want_on ? CNT_W'(T_MOD_CYC) : CNT_W'(T_XS_CYC);
        step_next = want_on ? S_LOCK : (ctrl_r[CTRL_ZQ] ? S_ZQ : S_REF);
      end
      S_LOCK: begin
        step_wait = CNT_W'(T_DLLK_CYC);
        step_next = ctrl_r[CTRL_ZQ] ? S_ZQ : S_REF;
      end
      S_ZQ: begin
        step_cmd  = CMD_ZQCL;
        step_wait = CNT_W'(T_ZQOPER_CYC);
        step_next = S_REF;
      end
      S_REF: begin
        step_cmd  = CMD_REF;
        step_wait = CNT_W'(T_RFC_CYC);
        step_next = S_PL_ON;
      end
      S_PL_ON: begin
        step_cmd  = CMD_MRS;
        step_mr   = MR5;
        step_addr[PL_LSB +: 3] = ctrl_r[CTRL_PL_LSB +: 3];
        step_next = S_IDLE;
      end
      default: begin
        step_next = S_IDLE;
      end
    endcase
  end

  assign tmr_load = (state_r != S_IDLE) && !waiting_r;

  wait_timer u_timer (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .load     (tmr_load),
    .load_val (step_wait),
    .done     (tmr_done)
  );

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_r   <= S_IDLE;
      waiting_r <= 1'b0;
      done_r    <= 1'b0;
    end else if (state_r == S_IDLE) begin
      if (go_r) begin
        state_r <= S_PL_OFF;
        done_r  <= 1'b0;
      end
    end else if (!waiting_r) begin
      waiting_r <= 1'b1;
    end else if (tmr_done) begin
      waiting_r <= 1'b0;
      state_r   <= step_next;
      done_r    <= (step_next == S_IDLE);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dram.cke    <= 1'b1;
      dram.odt    <= 1'b0;
      dram.cmd    <= CMD_DES;
      dram.mr_sel <= 3'h0;
      dram.addr   <= '0;
    end else begin
      dram.cmd    <= tmr_load ? step_cmd : CMD_DES;
      dram.mr_sel <= step_mr;
      dram.addr   <= step_addr;
      // cke drops the cycle after the entry command, rises with the exit command
      dram.cke    <= !((state_r == S_SRE && waiting_r) || (state_r == S_FREQ));
      dram.odt    <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rate_sel <= 1'b0;
      dll_on_r <= 1'b1;
    end else begin
      // rate flips only after tCKSRE, inside self refresh
      if (state_r == S_FREQ && !waiting_r) begin
        rate_sel <= ~rate_sel;
      end
      if (state_r == S_DLL_OFF && !waiting_r) begin
        dll_on_r <= 1'b0;
      end
      if (state_r == S_MR1_ON && !waiting_r) begin
        dll_on_r <= 1'b1;
      end
    end
  end
endmodule

// ### hw/dll_dram_end.sv
// Purpose: dram-side model of dll mode, self refresh exit windows and dll lock
// Assumes: commands sampled on clk_sys; SRE and SRX commands mark self refresh, cke is not used
// Notes:   violations set a sticky error flag; clearing loses no new event
`timescale 1ns/100ps
module dll_dram_end
  import dll_seq_pkg::*;
(
  input  wire logic  clk_sys,       // system clock
  input  wire logic  resetn,        // async reset, low
  input  wire logic  init_done,     // initialization finished
  input  wire logic  err_clr,       // clears cmd_err
  dram_cmd_if.device dram,          // link from the controller
  output logic       dll_on,        // dll enabled
  output logic       dll_locked,    // dll relocked
  output logic       in_sr,         // in self refresh
  output logic [15:0] refresh_count, // refresh counter
  output logic       cmd_err,       // sticky violation flag
  output logic       lat_ok,        // latency pair supported
  output logic [6:0] rd_ref_lat     // read strobe reference, cycles
);
  logic [CNT_W-1:0] xs_cnt_r;
  logic [CNT_W-1:0] lock_cnt_r;
  logic             post_sr_r;
  logic             abort_r;
  logic             pda_r;
  logic             mr6_pre_r;
  logic [4:0]       cl_r;
  logic [4:0]       cwl_r;
  logic [1:0]       al_r;
  logic             viol;

  wire is_mrs  = dram.cmd == CMD_MRS;
  wire is_sre  = dram.cmd == CMD_SRE;
  wire is_srx  = dram.cmd == CMD_SRX;
  wire is_zq   = dram.cmd == CMD_ZQCL || dram.cmd == CMD_ZQCS;
  wire is_dllr = is_mrs && dram.mr_sel == MR0 && dram.addr[DLL_RST_BIT];
  wire fast_ok = xs_cnt_r >= CNT_W'(T_XSFAST_CYC);
  wire full_ok = xs_cnt_r >= CNT_W'(T_XS_CYC) || (abort_r && xs_cnt_r >= CNT_W'(T_XSABORT_CYC));

  always_comb begin
    viol = 1'b0;
    if (post_sr_r && !full_ok && dram.cmd != CMD_DES) begin
      if (!fast_ok) begin
        viol = 1'b1;
      end else if (!(is_zq || (is_mrs && !pda_r && (dram.mr_sel == MR0 || dram.mr_sel == MR2)))) begin
        viol = 1'b1;
      end
    end
    // switching off from idle opens the off flow; switching on needs self refresh
    if (is_mrs && dram.mr_sel == MR1 && dram.addr[DLL_EN_BIT] && !dll_on && init_done && !post_sr_r) begin
      viol = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cmd_err <= 1'b0;
    end else if (viol) begin
      cmd_err <= 1'b1;
    end else if (err_clr) begin
      cmd_err <= 1'b0;
    end
  end

  // self refresh and the window that follows exit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      in_sr     <= 1'b0;
      post_sr_r <= 1'b0;
      xs_cnt_r  <= '0;
    end else begin
      if (is_sre) begin
        in_sr <= 1'b1;
      end else if (is_srx) begin
        in_sr     <= 1'b0;
        post_sr_r <= 1'b1;
        xs_cnt_r  <= '0;
      end else if (post_sr_r && !is_mrs && !is_zq && dram.cmd != CMD_DES) begin
        post_sr_r <= 1'b0;
      end
      if (post_sr_r && xs_cnt_r != {CNT_W{1'b1}}) begin
        xs_cnt_r <= xs_cnt_r + 1'b1;
      end
    end
  end

  // mode register copies
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dll_on  <= 1'b1;
      abort_r <= 1'b0;
      pda_r   <= 1'b0;
      cl_r    <= DLLOFF_CL;
      cwl_r   <= DLLOFF_CWL;
      al_r    <= 2'h0;
    end else if (is_mrs) begin
      case (dram.mr_sel)
        MR0: cl_r <= dram.addr[CL_LSB +: 5];
        MR1: begin
          dll_on <= dram.addr[DLL_EN_BIT];
          al_r   <= dram.addr[AL_LSB +: 2];
        end
        MR2: cwl_r <= dram.addr[CWL_LSB +: 5];
        MR3: pda_r <= dram.addr[PDA_BIT];
        MR4: abort_r <= dram.addr[ABORT_BIT];
        default: begin
        end
      endcase
    end
  end

  // an aborted exit skips the refresh in progress
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      refresh_count <= 16'h0000;
    end else if (dram.cmd == CMD_REF || (is_srx && !abort_r)) begin
      refresh_count <= refresh_count + 16'h0001;
    end
  end

  // relock after dll reset, or at exit when MR6 preceded entry
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mr6_pre_r  <= 1'b0;
      lock_cnt_r <= '0;
      dll_locked <= 1'b0;
    end else begin
      if (is_mrs && dram.mr_sel == MR6) begin
        mr6_pre_r <= !in_sr && !post_sr_r;
      end else if (is_srx) begin
        mr6_pre_r <= 1'b0;
      end
      if ((is_dllr && dll_on) || (is_srx && mr6_pre_r && dll_on)) begin
        lock_cnt_r <= CNT_W'(T_DLLK_CYC);
        dll_locked <= 1'b0;
      end else if (!dll_on || is_sre) begin
        dll_locked <= 1'b0;
      end else if (lock_cnt_r > CNT_W'(1)) begin
        lock_cnt_r <= lock_cnt_r - 1'b1;
      end else if (lock_cnt_r == CNT_W'(1)) begin
        lock_cnt_r <= '0;
        dll_locked <= 1'b1;
      end
    end
  end

  // latency checks for dll-off
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lat_ok     <= 1'b1;
      rd_ref_lat <= 7'h00;
    end else begin
      lat_ok     <= dll_on || (cl_r == DLLOFF_CL && cwl_r == DLLOFF_CWL);
      rd_ref_lat <= 7'(cl_r) + ((al_r == 2'h1) ? 7'(cl_r) - 7'h01 :
                                (al_r == 2'h2) ? 7'(cl_r) - 7'h02 : 7'h00)
                    - (dll_on ? 7'h00 : 7'h01);
    end
  end
endmodule

// ### sim/dll_seq_assertions.sv
// Purpose: link checks for the dll switch sequencer
// Assumes: one clock domain
// Notes:   sees only the command link
`timescale 1ns/100ps
module dll_seq_assertions
  import dll_seq_pkg::*;
(
  input wire logic              clk_sys, // clock
  input wire logic              resetn,  // reset
  input wire logic              cke,     // cke
  input wire logic              odt,     // odt
  input wire cmd_t              cmd,     // command
  input wire logic [2:0]        mr_sel,  // mr number
  input wire logic [ADDR_W-1:0] addr     // payload
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  sequence dll_rst;
    cmd == CMD_MRS && mr_sel == MR0 && addr[DLL_RST_BIT];
  endsequence
  sequence sr_entry;
    cmd == CMD_SRE ##1 !cke;
  endsequence
  odt_low_a: assert property (!odt) else $error("odt high");
  sre_cke_a: assert property (cmd == CMD_SRE |=> !cke) else $error("cke stays high");
  sr_hold_a: assert property (sr_entry |=> (!cke) [*8]) else $error("cke rose early");
  sr_quiet_a: assert property (!cke |-> cmd inside {CMD_DES, CMD_SRX}) else $error("cmd in sr");
  srx_sr_a: assert property (cmd == CMD_SRX |-> cke && !$past(cke)) else $error("bad exit");
  exit_wait_a: assert property (cmd == CMD_SRX |=> (cmd == CMD_DES) [*8]) else $error("exit early");
  mrs_gap_a: assert property (cmd == CMD_MRS |=> (cmd == CMD_DES) [*3]) else $error("mrs gap");
  ref_gap_a: assert property (cmd == CMD_REF |=> (cmd == CMD_DES) [*6]) else $error("ref gap");
  dll_order_a: assert property (cmd == CMD_MRS && mr_sel == MR1 && addr[DLL_EN_BIT] |-> ##[4:12] dll_rst)
    else $error("no dll reset");
  lock_cke_a: assert property (dll_rst |-> cke [*8]) else $error("cke low in lock");
endmodule

// ### sim/dll_switch_freq_change_seq_tb.sv
// Purpose: both ends joined, driven over axi
// Assumes: default latency register
// Notes:   dll target alternates off/on; random abort and parity, random zq in the last two rounds only
`timescale 1ns/100ps
module dll_switch_freq_change_seq_tb;
  import dll_seq_pkg::*;
  logic        clk_sys, resetn = 1'b0, init_done = 1'b0, err_clr = 1'b1;
  logic [31:0] s_awaddr = 32'h0, s_wdata = 32'h0, s_araddr = 32'h0, s_rdata, rng = 32'hDE3F, rd;
  logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, rate_sel, dll_on, dll_locked, in_sr, cmd_err;
  logic        lat_ok, seen = 1'b0, rate0 = 1'b0, dll, abrt, zq;
  logic [3:0]  s_wstrb = 4'hF;
  logic [1:0]  s_bresp, s_rresp, rsp;
  logic [15:0] refresh_count, ref0;
  logic [6:0]  rd_ref_lat;
  logic [2:0]  first_sel, last_sel, first_pl, last_pl, pl;
  int          mismatches = 0, n_compared = 0, n;
  dram_cmd_if link ();
  dll_seq_host dll_seq_host_inst (.clk_sys, .resetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .rate_sel, .dram(link.host));
  dll_dram_end dll_dram_end_inst (.clk_sys, .resetn, .init_done, .err_clr, .dram(link.device), .dll_on,
    .dll_locked, .in_sr, .refresh_count, .cmd_err, .lat_ok, .rd_ref_lat);
  dll_seq_assertions dll_seq_assertions_inst (.clk_sys, .resetn, .cke(link.cke), .odt(link.odt),
    .cmd(link.cmd), .mr_sel(link.mr_sel), .addr(link.addr));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // dll off reads one cycle earlier
  function automatic logic [6:0] exp_lat(input logic d);
    return d ? 7'(LAT_RST[4:0]) : 7'(DLLOFF_CL) - 7'h01;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic timeout();
    mismatches++;
    print_verdict();
  endtask
  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) break;
    end
    rsp = s_bresp;
    s_bready <= 1'b0;
    if (n == 50) timeout();
  endtask
  task automatic axr(input logic [31:0] a);
    @(posedge clk_sys);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) break;
    end
    rd = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'b0;
    if (n == 50) timeout();
  endtask
  // rate select may only move while the clock is gated off
  always @(posedge clk_sys) if (resetn) begin
    if (rate_sel !== rate0) chk(link.cke, 1'b0);
    rate0 <= rate_sel;
    if (link.cmd === CMD_MRS) begin
      if (!seen) first_sel <= link.mr_sel;
      if (!seen) first_pl <= link.addr[2:0];
      seen <= 1'b1;
      last_sel <= link.mr_sel;
      last_pl <= link.addr[2:0];
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    init_done <= 1'b1;
    err_clr <= 1'b0;
    axr(32'(REG_CTRL));
    chk({rd, rsp}, {CTRL_RST, RESP_OKAY});
    axr(32'(REG_LAT));
    chk(rd, LAT_RST);
    axr(32'h0C);
    chk(rsp, RESP_SLVERR);
    axw(32'h10, xs(rng));
    chk(rsp, RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      dll = i[0];
      abrt = rng[8];
      zq = rng[9] & i[1];
      pl = rng[2:0] | 3'h1;
      ref0 = refresh_count;
      seen = 1'b0;
      axw(32'(REG_CTRL), {25'h0, pl, zq, abrt, dll, 1'b1});
      axr(32'(REG_STATUS));
      chk(rd[0], 1'b1);
      axw(32'(REG_CTRL), {25'h0, ~pl, zq, abrt, ~dll, 1'b1});
      chk(rsp, RESP_OKAY);
      for (int k = 0; k < 3000 && !rd[1]; k++) axr(32'(REG_STATUS));
      if (!rd[1]) timeout();
      chk({rd[2], dll_on, dll_locked | ~dll}, {dll, dll, 1'b1});
      chk({lat_ok, rd_ref_lat}, {1'b1, exp_lat(dll)});
      chk({cmd_err, in_sr, rate_sel}, {2'b00, ~dll});
      chk({first_sel, first_pl, last_sel, last_pl}, {MR5, 3'h0, MR5, pl});
      chk(refresh_count > ref0, 1'b1);
      chk(refresh_count, ref0 + (abrt ? 16'h0001 : 16'h0002));
    end
    print_verdict();
  end
endmodule
